// ===== logic/dma_engine.sv
// Six-channel DMA engine with per-channel event synchronization and an idle domain.
// Assumes configuration arrives on plain ports and memory answers with a one-cycle ack.
`timescale 1ns/100ps
module dma_engine (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire dma_pkg::channel_cfg_t [dma_pkg::CHANNELS-1:0] channel_control_reg_i,
  input wire logic global_enable_i,
  input wire logic global_timeout_en_i,
  input wire logic domain_idle_req_i,
  input wire logic pll_active_i,
  input wire logic [2:0] sport_wake_req_i,
  input wire logic mux_strap_pin_i,
  input wire dma_pkg::sync_events_t sync_events_i,
  input wire logic cpu_ram_busy_i,
  input wire logic [dma_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output dma_pkg::mem_req_t mem_req_o,
  output logic [dma_pkg::CHANNELS-1:0] half_irq_o,
  output logic [dma_pkg::CHANNELS-1:0] done_irq_o,
  output logic [dma_pkg::CHANNELS-1:0] channel_busy_o,
  output logic domain_awake_o,
  output logic timeout_error_o,
  output logic sport2_mode_o
);
  localparam int CW = $clog2(dma_pkg::CHANNELS);
  localparam logic [7:0] TIMEOUT_CYCLES = 8'hff;

  logic mux_mode;
  logic strap_pending;
  logic [dma_pkg::CHANNELS-1:0] event_latch;
  logic [dma_pkg::CHANNELS-1:0] event_sel;
  logic [dma_pkg::CHANNELS-1:0] ready_ch;
  logic [dma_pkg::ADDR_W-1:0] src_ptr [dma_pkg::CHANNELS];
  logic [dma_pkg::ADDR_W-1:0] dst_ptr [dma_pkg::CHANNELS];
  logic [dma_pkg::COUNT_W-1:0] done_cnt [dma_pkg::CHANNELS];
  logic [dma_pkg::CHANNELS-1:0] active;
  logic [dma_pkg::CHANNELS-1:0] enable_q;
  dma_pkg::xfer_state_t state;
  logic [CW-1:0] cur;
  logic [CW-1:0] next_cur;
  logic grant_found;
  logic wake_hold;
  logic awake;
  logic [7:0] wait_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [dma_pkg::DATA_W-1:0] fifo_out_data;
  logic read_accept;
  logic write_accept;
  logic stall_cpu;

  // The strap is caught on the first clock after reset release and then frozen.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      strap_pending <= 1'b1;
      mux_mode <= 1'b0;
    end
    else if (strap_pending)
    begin
      strap_pending <= 1'b0;
      mux_mode <= mux_strap_pin_i;
    end
  end

  // Map each channel's code to one event line; reserved codes never fire.
  always_comb
  begin
    for (int c = 0; c < dma_pkg::CHANNELS; c++)
    begin
      case (channel_control_reg_i[c].sync)
        dma_pkg::SYNC_SP0_RX: event_sel[c] = sync_events_i.sport0_rx_event;
        dma_pkg::SYNC_SP0_TX: event_sel[c] = sync_events_i.sport0_tx_event;
        dma_pkg::SYNC_SP1_RX: event_sel[c] = sync_events_i.sport1_rx_event;
        dma_pkg::SYNC_SP1_TX: event_sel[c] = sync_events_i.sport1_tx_event;
        dma_pkg::SYNC_TIMER0: event_sel[c] = sync_events_i.timer0_event;
        dma_pkg::SYNC_TIMER1: event_sel[c] = sync_events_i.timer1_event;
        dma_pkg::SYNC_EXT0: event_sel[c] = sync_events_i.ext_int_event[0];
        dma_pkg::SYNC_EXT1: event_sel[c] = sync_events_i.ext_int_event[1];
        dma_pkg::SYNC_EXT2: event_sel[c] = sync_events_i.ext_int_event[2];
        dma_pkg::SYNC_EXT3: event_sel[c] = sync_events_i.ext_int_event[3];
        dma_pkg::SYNC_TWI_RX: event_sel[c] = sync_events_i.twi_rx_event;
        dma_pkg::SYNC_TWI_TX: event_sel[c] = sync_events_i.twi_tx_event;
        dma_pkg::SYNC_UART_RX: event_sel[c] = !mux_mode && sync_events_i.uart_rx_event;
        dma_pkg::SYNC_UART_TX: event_sel[c] = !mux_mode && sync_events_i.uart_tx_event;
        dma_pkg::SYNC_SP2_RX: event_sel[c] = mux_mode && sync_events_i.sport2_rx_event;
        dma_pkg::SYNC_SP2_TX: event_sel[c] = mux_mode && sync_events_i.sport2_tx_event;
        default: event_sel[c] = 1'b0;
      endcase
    end
  end

  // Pending events are sticky while the channel runs; a new event in the consuming cycle is kept.
  // An idle channel drops any pending event so a stale one cannot start the next block early.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      event_latch <= '0;
    end
    else
    begin
      for (int c = 0; c < dma_pkg::CHANNELS; c++)
      begin
        if (!active[c])
        begin
          event_latch[c] <= 1'b0;
        end
        else if (event_sel[c])
        begin
          event_latch[c] <= 1'b1;
        end
        else if (read_accept && cur == CW'(c))
        begin
          event_latch[c] <= 1'b0;
        end
      end
    end
  end

  // A channel is ready when active and either unsynchronized or its event is pending.
  always_comb
  begin
    for (int c = 0; c < dma_pkg::CHANNELS; c++)
    begin
      ready_ch[c] = active[c] && ((channel_control_reg_i[c].sync == dma_pkg::SYNC_NONE)
        || event_latch[c]);
    end
  end

  // Highest priority level wins; ties go to the lowest channel number.
  always_comb
  begin
    logic [dma_pkg::PRIO_W-1:0] best;
    best = '0;
    next_cur = '0;
    grant_found = 1'b0;
    for (int c = 0; c < dma_pkg::CHANNELS; c++)
    begin
      if (ready_ch[c] && (!grant_found || channel_control_reg_i[c].priority_level > best))
      begin
        grant_found = 1'b1;
        best = channel_control_reg_i[c].priority_level;
        next_cur = CW'(c);
      end
    end
  end

  // Serial port requests hold the domain awake while the PLL is active; it drops back once they go quiet.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wake_hold <= 1'b0;
      awake <= 1'b1;
    end
    else
    begin
      wake_hold <= pll_active_i && (sport_wake_req_i != 3'h0);
      awake <= !domain_idle_req_i || wake_hold || (state != dma_pkg::ST_IDLE);
    end
  end

  // The CPU owning a dual-access block stalls only internal-space accesses.
  assign stall_cpu = cpu_ram_busy_i && (mem_req_o.addr[dma_pkg::ADDR_W-1 -: 2] == dma_pkg::SPACE_INT);
  assign read_accept = (state == dma_pkg::ST_READ) && mem_ack_i && !stall_cpu;
  assign write_accept = (state == dma_pkg::ST_WRITE) && mem_ack_i && !stall_cpu;

  // Read data goes through the FIFO; write phase drains it.
  dma_fifo #(
    .WIDTH(dma_pkg::FIFO_W),
    .DEPTH(dma_pkg::FIFO_D)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(read_accept),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(write_accept),
    .out_data_o(fifo_out_data)
  );

  // Transfer sequencer: one element is read then written per grant.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state <= dma_pkg::ST_IDLE;
      cur <= '0;
      mem_req_o <= '0;
    end
    else
    begin
      case (state)
        dma_pkg::ST_IDLE:
        begin
          if (global_enable_i && awake && grant_found && fifo_in_ready)
          begin
            cur <= next_cur;
            state <= dma_pkg::ST_READ;
            mem_req_o.req <= 1'b1;
            mem_req_o.write <= 1'b0;
            mem_req_o.addr <= src_ptr[next_cur];
          end
        end
        dma_pkg::ST_READ:
        begin
          if (read_accept)
          begin
            state <= dma_pkg::ST_WRITE;
            mem_req_o.req <= 1'b0;
            mem_req_o.write <= 1'b1;
            mem_req_o.addr <= dst_ptr[cur];
          end
        end
        dma_pkg::ST_WRITE:
        begin
          mem_req_o.req <= fifo_out_valid;
          mem_req_o.wdata <= fifo_out_data;
          if (write_accept)
          begin
            state <= dma_pkg::ST_IDLE;
            mem_req_o <= '0;
          end
        end
        default: state <= dma_pkg::ST_IDLE;
      endcase
      if (timeout_error_o)
      begin
        state <= dma_pkg::ST_IDLE;
        mem_req_o <= '0;
      end
    end
  end

  // Global time-out watches for a stuck memory answer.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || state == dma_pkg::ST_IDLE || mem_ack_i)
    begin
      wait_cnt <= '0;
      timeout_error_o <= 1'b0;
    end
    else
    begin
      wait_cnt <= wait_cnt + 8'h01;
      timeout_error_o <= global_timeout_en_i && (wait_cnt == TIMEOUT_CYCLES);
    end
  end

  // Per-channel context: pointers, progress and interrupt pulses.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      active <= '0;
      enable_q <= '0;
      half_irq_o <= '0;
      done_irq_o <= '0;
      for (int c = 0; c < dma_pkg::CHANNELS; c++)
      begin
        src_ptr[c] <= '0;
        dst_ptr[c] <= '0;
        done_cnt[c] <= '0;
      end
    end
    else
    begin
      half_irq_o <= '0;
      done_irq_o <= '0;
      for (int c = 0; c < dma_pkg::CHANNELS; c++)
      begin
        enable_q[c] <= channel_control_reg_i[c].enable;
        if (channel_control_reg_i[c].enable && !enable_q[c])
        begin
          active[c] <= (channel_control_reg_i[c].elem_count != dma_pkg::COUNT_ZERO);
          src_ptr[c] <= channel_control_reg_i[c].src_addr;
          dst_ptr[c] <= channel_control_reg_i[c].dst_addr;
          done_cnt[c] <= '0;
        end
        else if (!channel_control_reg_i[c].enable)
        begin
          active[c] <= 1'b0;
        end
        if (read_accept && cur == CW'(c))
        begin
          src_ptr[c] <= src_ptr[c] + dma_pkg::ADDR_W'(channel_control_reg_i[c].src_index);
        end
        if (write_accept && cur == CW'(c))
        begin
          dst_ptr[c] <= dst_ptr[c] + dma_pkg::ADDR_W'(channel_control_reg_i[c].dst_index);
          done_cnt[c] <= done_cnt[c] + 16'h0001;
          if (done_cnt[c] + 16'h0001 == (channel_control_reg_i[c].elem_count >> 1))
          begin
            half_irq_o[c] <= channel_control_reg_i[c].half_irq_en;
          end
          if (done_cnt[c] + 16'h0001 == channel_control_reg_i[c].elem_count)
          begin
            done_irq_o[c] <= channel_control_reg_i[c].done_irq_en;
            active[c] <= 1'b0;
          end
        end
      end
    end
  end

  // Status outputs are registered copies of internal state.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      channel_busy_o <= '0;
      domain_awake_o <= 1'b1;
      sport2_mode_o <= 1'b0;
    end
    else
    begin
      channel_busy_o <= active;
      domain_awake_o <= awake;
      sport2_mode_o <= mux_mode;
    end
  end
endmodule

// ===== logic/dma_pkg.sv
// Shared constants and carrier types for the six-channel DMA engine.
// Assumes a single 25 MHz clock domain and plain-port configuration.
package dma_pkg;
  localparam int CHANNELS = 6;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SYNC_W = 5;
  localparam int PRIO_W = 2;
  localparam int COUNT_W = 16;
  localparam int INDEX_W = 16;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  localparam int EVENT_W = 32;
  // Event select codes for the per-channel sync field.
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_SP0_RX = 5'h01;
  localparam logic [4:0] SYNC_SP0_TX = 5'h02;
  localparam logic [4:0] SYNC_SP1_RX = 5'h05;
  localparam logic [4:0] SYNC_SP1_TX = 5'h06;
  localparam logic [4:0] SYNC_SP2_RX = 5'h09;
  localparam logic [4:0] SYNC_SP2_TX = 5'h0a;
  localparam logic [4:0] SYNC_UART_RX = 5'h0b;
  localparam logic [4:0] SYNC_UART_TX = 5'h0c;
  localparam logic [4:0] SYNC_TIMER0 = 5'h0d;
  localparam logic [4:0] SYNC_TIMER1 = 5'h0e;
  localparam logic [4:0] SYNC_EXT0 = 5'h0f;
  localparam logic [4:0] SYNC_EXT1 = 5'h10;
  localparam logic [4:0] SYNC_EXT2 = 5'h11;
  localparam logic [4:0] SYNC_EXT3 = 5'h12;
  localparam logic [4:0] SYNC_TWI_RX = 5'h13;
  localparam logic [4:0] SYNC_TWI_TX = 5'h14;
  // Address space selector in the top two address bits.
  localparam logic [1:0] SPACE_INT = 2'h0;
  localparam logic [1:0] SPACE_EXT = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // Per-channel configuration (the channel control register and its companions).
  typedef struct packed {
    logic enable;
    logic [PRIO_W-1:0] priority_level;
    logic [SYNC_W-1:0] sync;
    logic half_irq_en;
    logic done_irq_en;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [INDEX_W-1:0] src_index;
    logic [INDEX_W-1:0] dst_index;
    logic [COUNT_W-1:0] elem_count;
  } channel_cfg_t;

  // Memory bus request issued by the engine.
  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  // Raw synchronization event lines, one bit per SYNC code.
  typedef struct packed {
    logic sport0_rx_event;
    logic sport0_tx_event;
    logic sport1_rx_event;
    logic sport1_tx_event;
    logic sport2_rx_event;
    logic sport2_tx_event;
    logic uart_rx_event;
    logic uart_tx_event;
    logic timer0_event;
    logic timer1_event;
    logic [3:0] ext_int_event;
    logic twi_rx_event;
    logic twi_tx_event;
  } sync_events_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } xfer_state_t;
endpackage

// ===== logic/dma_fifo.sv
// Synchronous FIFO with valid/ready on both sides, used between read and write phases.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module dma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign in_ready_o = (fill != DEPTH[AW:0]);
  assign out_valid_o = (fill != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage is written only on an accepted push.
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill level move together so full and empty stay exact.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== testbench/dma_engine_props.sv
// Concurrent checks on the ports of the six-channel DMA engine.
// Assumes it is bound to dma_engine and clocked by its single clock.
`timescale 1ns/100ps
module dma_engine_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic global_enable_i,
  input wire logic global_timeout_en_i,
  input wire logic pll_active_i,
  input wire logic [2:0] sport_wake_req_i,
  input wire logic mux_strap_pin_i,
  input wire logic cpu_ram_busy_i,
  input wire logic mem_ack_i,
  input wire dma_pkg::mem_req_t mem_req_o,
  input wire logic [dma_pkg::CHANNELS-1:0] half_irq_o,
  input wire logic [dma_pkg::CHANNELS-1:0] done_irq_o,
  input wire logic domain_awake_o,
  input wire logic timeout_error_o,
  input wire logic sport2_mode_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // An internal access while the CPU holds the shared block must not complete.
  wire stall = (mem_req_o.addr[23:22] == dma_pkg::SPACE_INT) && cpu_ram_busy_i;

  AST_RESET_VALUES: assert property (disable iff (1'b0) rst_i |=>
    !mem_req_o.req && half_irq_o == '0 && done_irq_o == '0 && domain_awake_o) else $error("bad reset outputs");
  AST_CPU_WINS: assert property (mem_req_o.req && stall |=>
    (mem_req_o.req && $stable(mem_req_o.addr)) || timeout_error_o) else $error("access passed a busy CPU");
  AST_READ_THEN_WRITE: assert property (mem_req_o.req && !mem_req_o.write && mem_ack_i && !stall |=>
    !mem_req_o.req && mem_req_o.write ##1 mem_req_o.req && mem_req_o.write) else $error("read not followed by write");
  AST_WRITE_RETIRES: assert property (mem_req_o.req && mem_req_o.write && mem_ack_i && !stall |=>
    !mem_req_o.req) else $error("write did not retire");
  AST_START_GATED: assert property ($rose(mem_req_o.req) && !mem_req_o.write |->
    $past(global_enable_i) && domain_awake_o) else $error("element started while gated");
  AST_HALF_PULSE: assert property (|half_irq_o |=> (half_irq_o & $past(half_irq_o)) == '0)
    else $error("half pulse too long");
  AST_DONE_CAUSE: assert property (|done_irq_o |-> $past(mem_req_o.req && mem_req_o.write && mem_ack_i) ||
    $past(mem_req_o.req && mem_req_o.write && mem_ack_i, 2)) else $error("done without write ack");
  AST_TIMEOUT_GATED: assert property (timeout_error_o |-> $past(global_timeout_en_i) && !$past(timeout_error_o))
    else $error("bad timeout pulse");
  AST_WAKE: assert property (pll_active_i && |sport_wake_req_i |-> ##[1:3] domain_awake_o)
    else $error("port wake ignored");
  AST_STRAP: assert property ($past(rst_i, 3) && !$past(rst_i, 2) |-> sport2_mode_o == $past(mux_strap_pin_i, 2))
    else $error("strap not captured");
  AST_MODE_FIXED: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> $stable(sport2_mode_o))
    else $error("mux mode changed");

  C_DONE: cover property (|done_irq_o);
  C_HALF: cover property (|half_irq_o);
  C_TIMEOUT: cover property (timeout_error_o);
  C_STALL: cover property (mem_req_o.req && stall ##1 mem_req_o.req);
endmodule

// ===== testbench/mem_model.sv
// Behavioural memory answering the engine's requests in every address space.
// Assumes the engine holds each request until it sees the acknowledge.
`timescale 1ns/100ps
module mem_model (
  input wire logic clock_i,
  input wire dma_pkg::mem_req_t mem_req_i,
  input wire logic [7:0] ack_delay_i,
  input wire logic hold_ack_i,
  output logic mem_ack_o,
  output logic [dma_pkg::DATA_W-1:0] mem_rdata_o
);
  logic [15:0] mem [0:63];
  logic [7:0] wait_cnt;

  // Preload a known pattern so copied data can be traced.
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = 16'h5a00 + 16'(i);
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
    wait_cnt = 8'h00;
  end

  // Answer after the chosen wait; read data toggles outside the ack so stale data never looks valid.
  always @(posedge clock_i)
  begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!mem_req_i.req || mem_ack_o)
      wait_cnt <= 8'h00;
    else if (wait_cnt < ack_delay_i)
      wait_cnt <= wait_cnt + 8'h01;
    else if (!hold_ack_i)
    begin
      mem_ack_o <= 1'b1;
      if (mem_req_i.write)
        mem[mem_req_i.addr[5:0]] <= mem_req_i.wdata;
      else
        mem_rdata_o <= mem[mem_req_i.addr[5:0]];
    end
  end
endmodule

// ===== testbench/six_channel_dma_with_event_sync_tb.sv
// Self-checking bench for the DMA engine with a memory model on its bus.
// Assumes the engine contract: one element at a time, read then write.
`timescale 1ns/100ps
module six_channel_dma_with_event_sync_tb;
  logic clock_i, rst_i, global_enable, timeout_en, idle_req, pll_active, strap, cpu_busy, hold_ack, ack, awake;
  logic timeout_err, mode;
  dma_pkg::channel_cfg_t [dma_pkg::CHANNELS-1:0] cfg;
  logic [2:0] wake_req;
  logic [15:0] ev_vec, rdata;
  logic [7:0] ack_delay;
  dma_pkg::mem_req_t mem_req;
  logic [5:0] half_irq, done_irq;
  int n_mismatch, total_checks, cycles, first_done, to_cnt;
  int half_cnt [6];
  int done_cnt [6];
  logic [4:0] codes [16] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
    5'h0b, 5'h0c, 5'h09, 5'h0a};
  int bits [16] = '{15, 14, 13, 12, 7, 6, 2, 3, 4, 5, 1, 0, 9, 8, 11, 10};

  dma_engine dut (.clock_i(clock_i), .rst_i(rst_i), .channel_control_reg_i(cfg), .global_enable_i(global_enable),
    .global_timeout_en_i(timeout_en), .domain_idle_req_i(idle_req), .pll_active_i(pll_active),
    .sport_wake_req_i(wake_req), .mux_strap_pin_i(strap), .sync_events_i(dma_pkg::sync_events_t'(ev_vec)),
    .cpu_ram_busy_i(cpu_busy), .mem_rdata_i(rdata), .mem_ack_i(ack), .mem_req_o(mem_req), .half_irq_o(half_irq),
    .done_irq_o(done_irq), .channel_busy_o(), .domain_awake_o(awake), .timeout_error_o(timeout_err),
    .sport2_mode_o(mode));
  mem_model mem (.clock_i(clock_i), .mem_req_i(mem_req), .ack_delay_i(ack_delay), .hold_ack_i(hold_ack),
    .mem_ack_o(ack), .mem_rdata_o(rdata));

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Count pulses per channel; the cycle ceiling cuts a hang short.
  always @(posedge clock_i)
  begin
    cycles++;
    for (int c = 0; c < 6; c++)
    begin
      half_cnt[c] += int'(half_irq[c]);
      done_cnt[c] += int'(done_irq[c]);
      if (done_irq[c] && first_done < 0)
        first_done = c;
    end
    if (timeout_err)
      to_cnt++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clock_i);
    rst_i <= 1'b1;
    strap <= s;
    cfg <= '0;
    wait_cyc(12);
    rst_i <= 1'b0;
    wait_cyc(3);
  endtask

  // Program one channel disabled; enabling happens on a later edge so the rising edge is seen.
  task automatic setup(input int ch, input logic [4:0] code, input logic [1:0] prio, input logic [23:0] src,
    input logic [23:0] dst, input logic [15:0] si, input logic [15:0] di, input logic [15:0] cnt);
    @(posedge clock_i);
    cfg[ch] <= '{1'b0, prio, code, 1'b1, 1'b1, src, dst, si, di, cnt};
  endtask

  task automatic enable(input int ch, input logic en);
    @(posedge clock_i);
    cfg[ch].enable <= en;
  endtask

  // Wrong events must not start the channel; its own event must, unless the mux mode gates its code off.
  task automatic try_event(input int ch, input logic [4:0] code, input int bitn, input logic fires);
    int d0;
    d0 = done_cnt[ch];
    setup(ch, code, 2'h0, 24'h000030, 24'h400038, 16'h0001, 16'h0001, 16'h0001);
    enable(ch, 1'b1);
    wait_cyc(6);
    ev_vec <= ~(16'h0001 << bitn);
    @(posedge clock_i) ev_vec <= 16'h0000;
    wait_cyc(16);
    check("early start", done_cnt[ch] - d0, 0);
    @(posedge clock_i) ev_vec <= 16'h0001 << bitn;
    @(posedge clock_i) ev_vec <= 16'h0000;
    wait_cyc(16);
    check("event start", done_cnt[ch] - d0, 32'(fires));
    enable(ch, 1'b0);
    wait_cyc(2);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cfg = '0;
    {global_enable, timeout_en, idle_req, pll_active, strap, cpu_busy, hold_ack} = 7'b1001000;
    wake_req = 3'h0;
    ev_vec = 16'h0000;
    ack_delay = 8'h00;
    first_done = -1;
    do_reset(1'b0);
    // Unsynchronized block of four into I/O space with a slow memory.
    ack_delay <= 8'h02;
    setup(0, dma_pkg::SYNC_NONE, 2'h0, 24'h000010, 24'h800020, 16'h0001, 16'h0002, 16'h0004);
    enable(0, 1'b1);
    wait_cyc(120);
    check("done count", done_cnt[0], 1);
    check("half count", half_cnt[0], 1);
    for (int i = 0; i < 4; i++)
      check("copied word", mem.mem[6'h20 + 2 * i], 16'h5a10 + 16'(i));
    enable(0, 1'b0);
    ack_delay <= 8'h00;
    $display("test block copy end");
    // Every event code in both mux modes, spread over all channels.
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1)
        do_reset(1'b1);
      check("mux mode", mode, m);
      for (int i = 0; i < 16; i++)
        try_event(i % 6, codes[i], bits[i], (i < 12) || (m == 1 ? i >= 14 : i < 14));
    end
    $display("test event codes end");
    // The event sweep finished blocks on every channel; later tests count from zero.
    done_cnt = '{default: 0};
    // CPU holds the shared block: the element waits until it lets go.
    cpu_busy <= 1'b1;
    setup(1, dma_pkg::SYNC_NONE, 2'h0, 24'h000001, 24'h400002, 16'h0001, 16'h0001, 16'h0001);
    enable(1, 1'b1);
    wait_cyc(40);
    check("done while cpu busy", done_cnt[1], 0);
    cpu_busy <= 1'b0;
    wait_cyc(30);
    check("done after cpu", done_cnt[1], 1);
    enable(1, 1'b0);
    $display("test cpu priority end");
    // Two channels started together: the higher level finishes first.
    setup(2, dma_pkg::SYNC_NONE, 2'h1, 24'h000004, 24'h40000c, 16'h0001, 16'h0001, 16'h0002);
    setup(3, dma_pkg::SYNC_NONE, 2'h3, 24'h000004, 24'h40000c, 16'h0001, 16'h0001, 16'h0002);
    first_done = -1;
    @(posedge clock_i);
    cfg[2].enable <= 1'b1;
    cfg[3].enable <= 1'b1;
    wait_cyc(60);
    check("first done channel", first_done, 3);
    check("both done", done_cnt[2] + done_cnt[3], 2);
    enable(2, 1'b0);
    enable(3, 1'b0);
    $display("test priority end");
    // Idle domain, then a serial port wakes it for one transfer.
    idle_req <= 1'b1;
    wait_cyc(6);
    check("awake when idled", awake, 0);
    setup(4, dma_pkg::SYNC_NONE, 2'h0, 24'h000005, 24'h400006, 16'h0001, 16'h0001, 16'h0001);
    enable(4, 1'b1);
    wait_cyc(30);
    check("done while idle", done_cnt[4], 0);
    wake_req <= 3'h2;
    wait_cyc(30);
    check("awake on wake", awake, 1);
    check("done on wake", done_cnt[4], 1);
    wake_req <= 3'h0;
    wait_cyc(8);
    check("back to idle", awake, 0);
    enable(4, 1'b0);
    idle_req <= 1'b0;
    $display("test idle wake end");
    // Memory never answers: the time-out fires once after its wait.
    hold_ack <= 1'b1;
    timeout_en <= 1'b1;
    to_cnt = 0;
    setup(5, dma_pkg::SYNC_NONE, 2'h0, 24'h400007, 24'h400008, 16'h0001, 16'h0001, 16'h0001);
    enable(5, 1'b1);
    wait_cyc(200);
    check("early timeout", to_cnt, 0);
    wait_cyc(100);
    check("timeout", to_cnt, 1);
    enable(5, 1'b0);
    hold_ack <= 1'b0;
    $display("test timeout end");
    final_report();
  end
endmodule

bind dma_engine dma_engine_props chk (.clock_i(clock_i), .rst_i(rst_i), .global_enable_i(global_enable_i),
  .global_timeout_en_i(global_timeout_en_i), .pll_active_i(pll_active_i), .sport_wake_req_i(sport_wake_req_i),
  .mux_strap_pin_i(mux_strap_pin_i), .cpu_ram_busy_i(cpu_ram_busy_i), .mem_ack_i(mem_ack_i),
  .mem_req_o(mem_req_o), .half_irq_o(half_irq_o), .done_irq_o(done_irq_o), .domain_awake_o(domain_awake_o),
  .timeout_error_o(timeout_error_o), .sport2_mode_o(sport2_mode_o));
